// ---- lem_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lem_link_model (
  input  wire logic             i_clk,
  input  wire logic             i_go,
  input  wire logic [2:0]       i_kind,
  input  wire logic             i_bad,
  output lem_pkg::lem_link_ev_t o_link
);
  import lem_pkg::*;
  initial o_link = '0;
  // One-cycle event strobe; kind 7 steps the local period count
  always @(posedge i_clk) begin
    {o_link.phy_readback_arrived, o_link.cycle_start_tx_begin, o_link.subaction_gap_end, o_link.subunit_halt,
      o_link.cycle_start_rx, o_link.cycle_start_tx, o_link.arb_reset_gap} <= i_go ? 7'h40 >> i_kind : 7'h0;
    if (i_go && i_kind == 3'h7) begin
      o_link.timer_period_count_field <= o_link.timer_period_count_field + 13'h1;
    end
    // Received timer stamp disagrees with the local one on request
    o_link.rx_timer_seconds <= o_link.timer_seconds_field;
    o_link.rx_timer_count   <= o_link.timer_period_count_field ^ {12'h0, i_bad};
  end
endmodule
`default_nettype wire

// ---- lem_map.svh ----
`ifndef LEM_MAP_SVH
`define LEM_MAP_SVH
// Register byte offsets
`define LEM_OFF_CHAN_SET     8'h78
`define LEM_OFF_CHAN_CLR     8'h7c
`define LEM_OFF_EVT_SET      8'h80
`define LEM_OFF_EVT_CLR      8'h84
`define LEM_OFF_ENA_SET      8'h88
`define LEM_OFF_ENA_CLR      8'h8c
`define LEM_OFF_CTRL         8'h90
// Event and enable bit positions
`define LEM_BIT_IMPL         30
`define LEM_BIT_PHY_RB       26
`define LEM_BIT_OVERRUN      25
`define LEM_BIT_FATAL        24
`define LEM_BIT_MISMATCH     23
`define LEM_BIT_MISSED       22
`define LEM_BIT_MASTER_IE    31
// Writable event bits 26..22
`define LEM_EVT_MASK         32'h07c0_0000
`define LEM_ENA_MASK         32'h87c0_0000
// Period overrun limit
`define LEM_PERIOD_US        125
`define LEM_CLK_MHZ          50
`define LEM_PERIOD_CYC       (`LEM_PERIOD_US * `LEM_CLK_MHZ)
// AXI response codes
`define LEM_RESP_OKAY        2'b00
`define LEM_RESP_SLVERR      2'b10
`endif

// ---- lem_pkg.sv ----
package lem_pkg;
  // Internal event inputs of the link core
  typedef struct packed {
    logic phy_readback_arrived;
    logic cycle_start_tx_begin;
    logic subaction_gap_end;
    logic subunit_halt;
    logic cycle_start_rx;
    logic cycle_start_tx;
    logic arb_reset_gap;
    logic [6:0]  rx_timer_seconds;
    logic [12:0] rx_timer_count;
    logic [6:0]  timer_seconds_field;
    logic [12:0] timer_period_count_field;
  } lem_link_ev_t;

  // Bus-side access state
  typedef enum logic [1:0] {
    LEM_IDLE = 2'b00,
    LEM_WRSP = 2'b01,
    LEM_RRSP = 2'b10
  } lem_bus_st_t;

  typedef struct packed {
    lem_bus_st_t w_st;
    lem_bus_st_t r_st;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] chan_mask;
    logic [31:0] flags;
    logic [31:0] enables;
    logic        period_master_enable;
    logic        impl_bit;
    logic        halt_level;
    logic        in_overrun_win;
    logic [15:0] overrun_cnt;
    logic        sync_lsb;
    logic        start_seen;
    logic        gap_seen;
    logic        irq;
  } lem_state_t;
endpackage

// ---- lem_top.sv ----
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lem_map.svh"
// Functional notes
// - Mask bit n enables receive channel n
// - Channel mask set 78h, clear 7Ch
// - Event edge or write-one sets flag
// - Only clear-address write-one clears flag
// - Flags set 80h, clear 84h, masked read
// - Bits 31, 29-27 zero; 30 read-only
// - Bit 26 on PHY readback arrival
// - Overrun past 125us sets 25, drops master
// - Bit 24 on any subunit halt
// - Halt blocks ordinary events of failing context
// - Bit 23 on received timer mismatch
// - Bit 22 when period start missing
// - Early missed-start prediction allowed
// - Sync event on period count LSB toggle
// - Enable bits align with event bits
module lem_top #(
  parameter int unsigned OVERRUN_CYC = `LEM_PERIOD_CYC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire lem_pkg::lem_link_ev_t i_link,
  input  wire logic [7:0]           i_awaddr,
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  output logic [1:0]                o_bresp,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  input  wire logic [7:0]           i_araddr,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  output logic [31:0]               o_iso_rx_chan_enable_bit,
  output logic                      o_period_master_enable,
  output logic                      o_irq
);
  import lem_pkg::*;

  logic [1:0]   rst_sync_q;
  logic         rst_n;
  lem_state_t   s_q;
  lem_state_t   s_d;
  lem_link_ev_t ev_q;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Previous link inputs for edge detection
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= '0;
    end else begin
      ev_q <= i_link;
    end
  end

  // Byte-lane mask of write data; unstrobed lanes read as zero
  function automatic logic [31:0] lem_strb(input logic [31:0] d, input logic [3:0] b);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Known register address check
  function automatic logic lem_hit(input logic [7:0] a);
    return (a == `LEM_OFF_CHAN_SET) || (a == `LEM_OFF_CHAN_CLR) || (a == `LEM_OFF_EVT_SET) ||
           (a == `LEM_OFF_EVT_CLR) || (a == `LEM_OFF_ENA_SET) || (a == `LEM_OFF_ENA_CLR) ||
           (a == `LEM_OFF_CTRL);
  endfunction

  // Visible event word with reserved bits zero
  function automatic logic [31:0] lem_evt_view(input logic [31:0] f, input logic impl);
    logic [31:0] r;
    r = f & `LEM_EVT_MASK;
    r[`LEM_BIT_IMPL] = impl;
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    logic [31:0] wv;
    logic [31:0] hw_set;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic        wr_go;
    logic        sync_ev;
    logic        start_ev;
    logic        overrun;
    logic        halt_now;
    wv       = '0;
    hw_set   = '0;
    sw_set   = '0;
    sw_clr   = '0;
    wr_go    = 1'b0;
    sync_ev  = 1'b0;
    start_ev = 1'b0;
    overrun  = 1'b0;
    halt_now = 1'b0;
    s_d      = s_q;

    // Write channel capture, either order
    if (!s_q.aw_have && i_awvalid) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = i_awaddr;
    end
    if (!s_q.w_have && i_wvalid) begin
      s_d.w_have = 1'b1;
      s_d.w_data = i_wdata;
      s_d.w_strb = i_wstrb;
    end
    if (s_q.w_st == LEM_IDLE && s_q.aw_have && s_q.w_have) begin
      wr_go       = 1'b1;
      wv          = lem_strb(s_q.w_data, s_q.w_strb);
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.w_st    = LEM_WRSP;
      s_d.bresp   = lem_hit(s_q.aw_addr) ? `LEM_RESP_OKAY : `LEM_RESP_SLVERR;
    end
    if (s_q.w_st == LEM_WRSP && i_bready) begin
      s_d.w_st = LEM_IDLE;
    end

    // Register writes
    if (wr_go) begin
      unique case (s_q.aw_addr)
        `LEM_OFF_CHAN_SET: s_d.chan_mask = s_q.chan_mask | wv;
        `LEM_OFF_CHAN_CLR: s_d.chan_mask = s_q.chan_mask & ~wv;
        `LEM_OFF_EVT_SET:  sw_set = wv & `LEM_EVT_MASK;
        `LEM_OFF_EVT_CLR:  sw_clr = wv & `LEM_EVT_MASK;
        `LEM_OFF_ENA_SET:  s_d.enables = s_q.enables | (wv & `LEM_ENA_MASK);
        `LEM_OFF_ENA_CLR:  s_d.enables = s_q.enables & ~(wv & `LEM_ENA_MASK);
        `LEM_OFF_CTRL: begin
          s_d.period_master_enable = wv[0];
          s_d.impl_bit             = wv[1];
        end
        default: ;
      endcase
    end

    // Period sync and start detection
    sync_ev  = i_link.timer_period_count_field[0] != s_q.sync_lsb;
    s_d.sync_lsb = i_link.timer_period_count_field[0];
    start_ev = (i_link.cycle_start_rx && !ev_q.cycle_start_rx) ||
               (i_link.cycle_start_tx && !ev_q.cycle_start_tx);

    // Halt edge; halt state blocks ordinary events
    halt_now = i_link.subunit_halt && !ev_q.subunit_halt;
    if (halt_now) begin
      hw_set[`LEM_BIT_FATAL] = 1'b1;
    end
    s_d.halt_level = s_q.flags[`LEM_BIT_FATAL] | halt_now;

    if (!s_q.halt_level) begin
      if (i_link.phy_readback_arrived && !ev_q.phy_readback_arrived) begin
        hw_set[`LEM_BIT_PHY_RB] = 1'b1;
      end
      if (i_link.cycle_start_rx && !ev_q.cycle_start_rx &&
          (i_link.rx_timer_seconds != i_link.timer_seconds_field ||
           i_link.rx_timer_count != i_link.timer_period_count_field)) begin
        hw_set[`LEM_BIT_MISMATCH] = 1'b1;
      end
    end

    // Overrun window timing while master
    if (i_link.cycle_start_tx_begin && !ev_q.cycle_start_tx_begin && s_q.period_master_enable) begin
      s_d.in_overrun_win = 1'b1;
      s_d.overrun_cnt    = '0;
    end else if (s_q.in_overrun_win) begin
      if (i_link.subaction_gap_end && !ev_q.subaction_gap_end) begin
        s_d.in_overrun_win = 1'b0;
      end else if (32'(s_q.overrun_cnt) >= OVERRUN_CYC) begin
        overrun = 1'b1;
        s_d.in_overrun_win = 1'b0;
      end else begin
        s_d.overrun_cnt = s_q.overrun_cnt + 16'h0001;
      end
    end
    if (overrun && !s_q.halt_level) begin
      hw_set[`LEM_BIT_OVERRUN] = 1'b1;
    end
    if (overrun) begin
      s_d.period_master_enable = 1'b0;
    end

    // Missed period start detection and prediction
    if (start_ev) begin
      s_d.start_seen = 1'b1;
      s_d.gap_seen   = 1'b1;
    end
    if (!s_q.start_seen && !start_ev && !s_q.halt_level &&
        ((i_link.subaction_gap_end && !ev_q.subaction_gap_end && !s_q.gap_seen) ||
         (i_link.arb_reset_gap && !ev_q.arb_reset_gap))) begin
      hw_set[`LEM_BIT_MISSED] = 1'b1;
    end
    if (i_link.subaction_gap_end && !ev_q.subaction_gap_end) begin
      s_d.gap_seen = 1'b1;
    end
    if (sync_ev) begin
      if (!s_q.start_seen && !start_ev && !s_q.halt_level) begin
        hw_set[`LEM_BIT_MISSED] = 1'b1;
      end
      s_d.start_seen = 1'b0;
      s_d.gap_seen   = 1'b0;
    end

    // Sticky flags: set wins over clear
    s_d.flags = ((s_q.flags & ~sw_clr) | sw_set | hw_set) & `LEM_EVT_MASK;

    // Read channel
    if (s_q.r_st == LEM_IDLE && i_arvalid) begin
      s_d.r_st  = LEM_RRSP;
      s_d.rresp = lem_hit(i_araddr) ? `LEM_RESP_OKAY : `LEM_RESP_SLVERR;
      unique case (i_araddr)
        `LEM_OFF_CHAN_SET, `LEM_OFF_CHAN_CLR: s_d.rdata = s_q.chan_mask;
        `LEM_OFF_EVT_SET: s_d.rdata = lem_evt_view(s_q.flags, s_q.impl_bit);
        `LEM_OFF_EVT_CLR: s_d.rdata = lem_evt_view(s_q.flags, s_q.impl_bit) & s_q.enables;
        `LEM_OFF_ENA_SET, `LEM_OFF_ENA_CLR: s_d.rdata = s_q.enables;
        `LEM_OFF_CTRL: s_d.rdata = {30'h0000_0000, s_q.impl_bit, s_q.period_master_enable};
        default: s_d.rdata = '0;
      endcase
    end else if (s_q.r_st == LEM_RRSP && i_rready) begin
      s_d.r_st = LEM_IDLE;
    end

    // Interrupt level from enabled flags
    s_d.irq = s_q.enables[`LEM_BIT_MASTER_IE] &&
              (|(s_q.flags & s_q.enables & `LEM_EVT_MASK));
  end

  // State register
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign o_awready                = !s_q.aw_have;
  assign o_wready                 = !s_q.w_have;
  assign o_bvalid                 = s_q.w_st == LEM_WRSP;
  assign o_bresp                  = s_q.bresp;
  assign o_arready                = s_q.r_st == LEM_IDLE;
  assign o_rvalid                 = s_q.r_st == LEM_RRSP;
  assign o_rdata                  = s_q.rdata;
  assign o_rresp                  = s_q.rresp;
  assign o_iso_rx_chan_enable_bit = s_q.chan_mask;
  assign o_period_master_enable   = s_q.period_master_enable;
  assign o_irq                    = s_q.irq;
endmodule
`default_nettype wire

// ---- lem_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lem_map.svh"
module lem_top_assertions #(
  parameter int unsigned OVERRUN_CYC = `LEM_PERIOD_CYC
) (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        i_awvalid,
  input wire logic        i_wvalid,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_arready,
  input wire logic        o_bvalid,
  input wire logic        o_rvalid,
  input wire logic [1:0]  o_rresp,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_iso_rx_chan_enable_bit,
  input wire logic        o_period_master_enable,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Request hand-offs on the register bus
  sequence wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence rd_taken;
    i_arvalid && o_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##[1:2] o_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (rd_taken |=> o_rvalid)
    else $error("read response missing");
  ar_refuse_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while busy");
  unmapped_a: assert property (i_arvalid && o_arready && !(i_araddr inside {8'h78, 8'h7c, 8'h80, 8'h84,
      8'h88, 8'h8c, 8'h90}) |=> o_rresp == `LEM_RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  flag_zero_a: assert property (rd_taken ##0 i_araddr[7:3] == 5'h10 |=> o_rdata[31] == 1'b0
      && o_rdata[29:27] == 3'h0)
    else $error("reserved flag bits not zero");
  mask_write_a: assert property ($changed(o_iso_rx_chan_enable_bit) |-> o_bvalid)
    else $error("channel mask moved without write");
  irq_clear_a: assert property ($fell(o_irq) |-> o_bvalid || $past(o_bvalid))
    else $error("interrupt dropped without write");
  master_set_a: assert property ($rose(o_period_master_enable) |-> o_bvalid)
    else $error("master enable rose without write");
endmodule
bind lem_top lem_top_assertions #(.OVERRUN_CYC(OVERRUN_CYC)) u_chk (.i_clk, .i_resetn, .i_araddr, .i_arvalid,
  .i_awvalid, .i_wvalid, .o_awready, .o_wready, .o_arready, .o_bvalid, .o_rvalid, .o_rresp, .o_rdata,
  .o_iso_rx_chan_enable_bit, .o_period_master_enable, .o_irq);
`default_nettype wire

// ---- lem_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module lem_top_tb;
  import lem_pkg::*;
  logic         i_clk = 1'b0, i_resetn = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic         i_arvalid = 1'b0, i_rready = 1'b0, go = 1'b0, bad = 1'b0;
  logic [7:0]   i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [31:0]  i_wdata = 32'h0, r, c;
  logic [3:0]   i_wstrb = 4'hf;
  logic [2:0]   kind = 3'h0;
  logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_period_master_enable, o_irq;
  logic [1:0]   o_bresp, o_rresp;
  logic [31:0]  o_rdata, o_iso_rx_chan_enable_bit;
  lem_link_ev_t i_link;
  logic [33:0]  expq[$];
  logic [15:0]  lfsr = 16'hb979;
  int           compares = 0, miscompares = 0;
  lem_link_model u_link (.i_clk, .i_go(go), .i_kind(kind), .i_bad(bad), .o_link(i_link));
  lem_top #(.OVERRUN_CYC(20)) DUT (.i_clk, .i_resetn, .i_link, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_iso_rx_chan_enable_bit, .o_period_master_enable, .o_irq);
  initial forever #10 i_clk = ~i_clk;
  function automatic logic [15:0] nxt();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Register write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge i_clk);
      ta = ta | o_awready;
      tw = tw | o_wready;
      i_awvalid <= ~ta;
      i_wvalid <= ~tw;
    end
    do @(posedge i_clk); while (!o_bvalid);
    // Response code stands with bvalid: known offsets answer OKAY, others SLVERR
    chk({32'h0, o_bresp}, {32'h0, (a inside {8'h78, 8'h7c, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h90}) ? 2'b00 : 2'b10});
    i_bready <= 1'b0;
  endtask
  // Register read; the monitor compares the answer
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (!o_rvalid);
    i_rready <= 1'b0;
  endtask
  task automatic ev(input logic [2:0] k, input logic b);
    @(posedge i_clk);
    kind <= k;
    bad <= b;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  // Clear every flag, raise one link event, read the gated flags
  task automatic tev(input logic [2:0] k, input logic b, input logic [31:0] e);
    wr(8'h84, 32'hffff_ffff);
    rd(8'h84, 34'h0);
    ev(k, b);
    rd(8'h84, {2'b00, e});
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read answers against the oldest expectation
  always @(posedge i_clk) if (o_rvalid && i_rready) chk({o_rresp, o_rdata}, expq.pop_front());
  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(8'h78, 34'h0);
    r = {nxt(), nxt()};
    c = {nxt(), nxt()};
    wr(8'h78, r);
    rd(8'h7c, {2'b00, r});
    chk({2'b00, o_iso_rx_chan_enable_bit}, {2'b00, r});
    wr(8'h7c, c);
    rd(8'h78, {2'b00, r & ~c});
    rd(8'h40, {2'b10, 32'h0});
    wr(8'h44, 32'h1);
    wr(8'h88, 32'h87c0_0000);
    wr(8'h80, 32'hffff_ffff);
    rd(8'h84, 34'h07c0_0000);
    repeat (2) @(posedge i_clk);
    chk({33'h0, o_irq}, 34'h1);
    wr(8'h8c, 32'h8000_0000);
    repeat (2) @(posedge i_clk);
    chk({33'h0, o_irq}, 34'h0);
    wr(8'h88, 32'h8000_0000);
    tev(3'h0, 1'b0, 32'h0400_0000);
    tev(3'h3, 1'b0, 32'h0100_0000);
    ev(3'h0, 1'b0);
    rd(8'h84, 34'h0100_0000);
    tev(3'h4, 1'b1, 32'h0080_0000);
    tev(3'h4, 1'b0, 32'h0);
    wr(8'h8c, 32'h0040_0000);
    wr(8'h90, 32'h1);
    chk({33'h0, o_period_master_enable}, 34'h1);
    for (int i = 0; i < 2; i++) begin
      wr(8'h84, 32'hffff_ffff);
      ev(3'h1, 1'b0);
      repeat (i * 25) @(posedge i_clk);
      ev(3'h2, 1'b0);
      rd(8'h84, (i == 1) ? 34'h0200_0000 : 34'h0);
      chk({33'h0, o_period_master_enable}, {33'h0, i == 0});
    end
    wr(8'h88, 32'h0040_0000);
    ev(3'h7, 1'b0);
    tev(3'h7, 1'b0, 32'h0040_0000);
    tev(3'h6, 1'b0, 32'h0040_0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
